// [design/tsovd_pkg.sv]
/*
  Package for the three-stage overvoltage detector: register map, field
  layouts, reset values and timing constants.
  Assumes a 125 MHz system clock and a 32-bit APB register bus.
*/
package tsovd_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned FORCE_TIMEOUT_S  = 300;
  localparam longint unsigned FORCE_TIMEOUT_CYC = longint'(FORCE_TIMEOUT_S) * CLK_HZ;

  // ==========================================================================
  // Widths
  localparam int unsigned VOLT_W  = 16;
  localparam int unsigned TIME_W  = 32;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned NSTAGE  = 3;
  localparam int unsigned NGROUP  = 4;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS  = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h00C;
  localparam logic [11:0] UMAX_OFS      = 12'h010;
  localparam logic [11:0] HYST_OFS      = 12'h014;
  localparam logic [11:0] RELDLY_OFS    = 12'h018;
  localparam logic [11:0] CNT_BASE_OFS  = 12'h020;
  localparam logic [11:0] SET_BASE_OFS  = 12'h100;
  // Settings: base + stage*0x40 + group*0x10 + {0:pick-up, 4:operate delay}
  localparam logic [11:0] SET_STAGE_STRIDE = 12'h040;
  localparam logic [11:0] SET_GROUP_STRIDE = 12'h010;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned CTRL_GRP_LSB    = 0;
  localparam int unsigned CTRL_GRPSRC_BIT = 2;
  localparam int unsigned CTRL_FORCE_BIT  = 3;
  localparam int unsigned CTRL_FSTART_LSB = 4;
  localparam int unsigned CTRL_FTRIP_LSB  = 8;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  // Hysteresis in units of 1/1024 of the pick-up; 31/1024 is about 3 %
  localparam logic [9:0]  HYST_RST        = 10'h01F;
  localparam int unsigned HYST_FRAC_W     = 10;
  localparam logic [VOLT_W-1:0] PICKUP_RST = 16'hFFFF;
  localparam logic [TIME_W-1:0] DELAY_RST  = 32'h0000_0064;
  localparam logic [TIME_W-1:0] RELDLY_RST = 32'h0000_0000;

endpackage

// [design/tsovd_top.sv]
/*
  Three-stage definite-time overvoltage detector with APB register slave.
  Assumes line-to-line fundamental magnitudes synchronous to sys_clk,
  an APB master on the same clock, and settings loaded by software.
*/
`timescale 1ns/1ps
`default_nettype none
module tsovd_top #(
  parameter longint unsigned FORCE_TIMEOUT = tsovd_pkg::FORCE_TIMEOUT_CYC
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [tsovd_pkg::VOLT_W-1:0]  u12_fund,
  input  wire logic [tsovd_pkg::VOLT_W-1:0]  u23_fund,
  input  wire logic [tsovd_pkg::VOLT_W-1:0]  u31_fund,
  input  wire logic [1:0]                    group_select_in,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic      [2:0]                    start_out,
  output logic      [2:0]                    trip_out,
  output logic                               irq
);
  import tsovd_pkg::*;

  // A zero timeout would leave the force flag stuck on
  if (FORCE_TIMEOUT == 0) begin : g_bad_timeout
    $error("FORCE_TIMEOUT must be nonzero");
  end

  // ==========================================================================
  // Supervised value
  logic [VOLT_W-1:0] umax;
  always_comb begin
    umax = u12_fund;
    if (u23_fund > umax) umax = u23_fund;
    if (u31_fund > umax) umax = u31_fund;
  end

  // ==========================================================================
  // Setting registers
  logic [VOLT_W-1:0] pickup_reg [NSTAGE][NGROUP];
  logic [TIME_W-1:0] delay_reg  [NSTAGE][NGROUP];
  logic [VOLT_W-1:0] pickup_next [NSTAGE][NGROUP];
  logic [TIME_W-1:0] delay_next  [NSTAGE][NGROUP];
  logic [31:0]       ctrl_reg, ctrl_next;
  logic [9:0]        hyst_reg, hyst_next;
  logic [TIME_W-1:0] reldly_reg, reldly_next;
  logic [5:0]        irq_mask_reg, irq_mask_next;
  logic [5:0]        irq_stat_reg, irq_stat_next;
  logic [CNT_W-1:0]  scnt_reg [NSTAGE];
  logic [CNT_W-1:0]  tcnt_reg [NSTAGE];
  logic [CNT_W-1:0]  scnt_next [NSTAGE];
  logic [CNT_W-1:0]  tcnt_next [NSTAGE];
  logic [63:0]       force_cnt_reg, force_cnt_next;

  logic        wr_en;
  logic        rd_en;
  logic        rd_setup;
  logic [1:0]  grp;
  logic        force_on;
  logic [2:0]  start_raw;
  logic [2:0]  trip_raw;
  logic [2:0]  start_eff;
  logic [2:0]  trip_eff;
  logic [2:0]  start_prev_reg;
  logic [2:0]  trip_prev_reg;

  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign force_on = ctrl_reg[CTRL_FORCE_BIT];
  // Active group comes from the input pin or from software
  assign grp = ctrl_reg[CTRL_GRPSRC_BIT] ? group_select_in
                                         : ctrl_reg[CTRL_GRP_LSB +: 2];

  // ==========================================================================
  // Stages
  logic [VOLT_W-1:0] hyst_lvl [NSTAGE];
  logic [TIME_W-1:0] op_tmr_reg [NSTAGE];
  logic [TIME_W-1:0] op_tmr_next [NSTAGE];
  logic [TIME_W-1:0] rel_tmr_reg, rel_tmr_next;
  logic [2:0]        pick_reg, pick_next;
  logic [2:0]        trip_reg, trip_next;

  genvar s;
  generate
    for (s = 0; s < NSTAGE; s++) begin : g_stage
      logic [VOLT_W+HYST_FRAC_W-1:0] prod;
      always_comb begin
        prod = pickup_reg[s][grp] * hyst_reg;
        hyst_lvl[s] = pickup_reg[s][grp] - prod[VOLT_W+HYST_FRAC_W-1:HYST_FRAC_W];
      end

      always_comb begin
        logic fault;
        fault = pick_reg[s] ? (umax >= hyst_lvl[s])
                            : (umax > pickup_reg[s][grp]);
        pick_next[s]   = pick_reg[s];
        trip_next[s]   = trip_reg[s];
        op_tmr_next[s] = op_tmr_reg[s];
        if (fault) begin
          pick_next[s] = 1'b1;
          if (op_tmr_reg[s] >= delay_reg[s][grp]) begin
            trip_next[s] = 1'b1;
          end else begin
            op_tmr_next[s] = op_tmr_reg[s] + 1'b1;
          end
        end else if (s != 0 || rel_tmr_reg >= reldly_reg) begin
          pick_next[s]   = 1'b0;
          trip_next[s]   = 1'b0;
          op_tmr_next[s] = '0;
        end else begin
          pick_next[s] = 1'b0;
          trip_next[s] = 1'b0;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          op_tmr_reg[s] <= '0;
          pick_reg[s]   <= 1'b0;
          trip_reg[s]   <= 1'b0;
        end else begin
          op_tmr_reg[s] <= op_tmr_next[s];
          pick_reg[s]   <= pick_next[s];
          trip_reg[s]   <= trip_next[s];
        end
      end
    end
  endgenerate

  // Low stage release timer runs while its timer is held without a fault
  always_comb begin
    rel_tmr_next = '0;
    if (!pick_next[0] && op_tmr_reg[0] != '0 && rel_tmr_reg < reldly_reg) begin
      rel_tmr_next = rel_tmr_reg + 1'b1;
    end
  end

  // Force flag allows software to override the outputs for testing
  always_comb begin
    start_raw = pick_reg;
    trip_raw  = trip_reg;
    start_eff = force_on ? ctrl_reg[CTRL_FSTART_LSB +: 3] : start_raw;
    trip_eff  = force_on ? ctrl_reg[CTRL_FTRIP_LSB +: 3]  : trip_raw;
  end

  // ==========================================================================
  // Counters, interrupts and registers
  logic [31:0] rdata_next;
  logic [11:0] sofs;
  logic [1:0]  sidx;
  logic [1:0]  gidx;
  logic        set_hit;

  always_comb begin
    sofs = paddr - SET_BASE_OFS;
    sidx = sofs[7:6];
    gidx = sofs[5:4];
    // Window ends after the last stage so higher offsets cannot alias stage 0
    set_hit = paddr >= SET_BASE_OFS && sofs[11:8] == 4'h0 && sidx < 2'(NSTAGE)
              && paddr[3] == 1'b0;
  end

  always_comb begin
    ctrl_next     = ctrl_reg;
    hyst_next     = hyst_reg;
    reldly_next   = reldly_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    pickup_next   = pickup_reg;
    delay_next    = delay_reg;
    scnt_next     = scnt_reg;
    tcnt_next     = tcnt_reg;
    force_cnt_next = force_on ? force_cnt_reg + 64'h1 : 64'h0;
    rdata_next    = 32'h0000_0000;
    pslverr       = 1'b0;
    // Read word is captured in the setup cycle so it stands in the access cycle
    if (psel && !pwrite) begin
      unique case (paddr)
        CTRL_OFS:     rdata_next = ctrl_reg;
        STATUS_OFS:   rdata_next = {26'h0, trip_eff, start_eff};
        IRQ_STAT_OFS: begin
          rdata_next    = {26'h0, irq_stat_reg};
          // Clear only what the captured word reported; later events survive
          if (rd_en) irq_stat_next = irq_stat_reg & ~prdata[5:0];
        end
        IRQ_MASK_OFS: rdata_next = {26'h0, irq_mask_reg};
        UMAX_OFS:     rdata_next = {16'h0, umax};
        HYST_OFS:     rdata_next = {22'h0, hyst_reg};
        RELDLY_OFS:   rdata_next = reldly_reg;
        CNT_BASE_OFS, 12'h024, 12'h028:
          rdata_next = {tcnt_reg[paddr[3:2]], scnt_reg[paddr[3:2]]};
        default: begin
          if (set_hit) begin
            rdata_next = paddr[2] ? delay_reg[sidx][gidx]
                                  : {16'h0, pickup_reg[sidx][gidx]};
          end else begin
            pslverr = rd_en;
          end
        end
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        CTRL_OFS:     ctrl_next = pwdata;
        IRQ_MASK_OFS: irq_mask_next = pwdata[5:0];
        HYST_OFS:     hyst_next = pwdata[9:0];
        RELDLY_OFS:   reldly_next = pwdata;
        CNT_BASE_OFS, 12'h024, 12'h028: begin
          scnt_next[paddr[3:2]] = '0;
          tcnt_next[paddr[3:2]] = '0;
        end
        default: begin
          if (set_hit) begin
            if (paddr[2]) delay_next[sidx][gidx] = pwdata;
            else pickup_next[sidx][gidx] = pwdata[VOLT_W-1:0];
          end else begin
            pslverr = 1'b1;
          end
        end
      endcase
    end
    if (force_cnt_reg >= FORCE_TIMEOUT - 1) begin
      ctrl_next[CTRL_FORCE_BIT] = 1'b0;
      force_cnt_next = 64'h0;
    end
    for (int i = 0; i < NSTAGE; i++) begin
      if (start_eff[i] && !start_prev_reg[i]) begin
        scnt_next[i] = scnt_next[i] + 1'b1;
        irq_stat_next[i] = 1'b1;
      end
      if (trip_eff[i] && !trip_prev_reg[i]) begin
        tcnt_next[i] = tcnt_next[i] + 1'b1;
        irq_stat_next[3+i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg       <= CTRL_RST;
      hyst_reg       <= HYST_RST;
      reldly_reg     <= RELDLY_RST;
      irq_mask_reg   <= 6'h00;
      irq_stat_reg   <= 6'h00;
      force_cnt_reg  <= 64'h0;
      rel_tmr_reg    <= '0;
      start_prev_reg <= 3'h0;
      trip_prev_reg  <= 3'h0;
      prdata         <= 32'h0000_0000;
      start_out      <= 3'h0;
      trip_out       <= 3'h0;
      irq            <= 1'b0;
      for (int i = 0; i < NSTAGE; i++) begin
        scnt_reg[i] <= '0;
        tcnt_reg[i] <= '0;
        for (int g = 0; g < NGROUP; g++) begin
          pickup_reg[i][g] <= PICKUP_RST;
          delay_reg[i][g]  <= DELAY_RST;
        end
      end
    end else begin
      ctrl_reg       <= ctrl_next;
      hyst_reg       <= hyst_next;
      reldly_reg     <= reldly_next;
      irq_mask_reg   <= irq_mask_next;
      irq_stat_reg   <= irq_stat_next;
      force_cnt_reg  <= force_cnt_next;
      rel_tmr_reg    <= rel_tmr_next;
      start_prev_reg <= start_eff;
      trip_prev_reg  <= trip_eff;
      prdata         <= rd_setup ? rdata_next : prdata;
      start_out      <= start_eff;
      trip_out       <= trip_eff;
      irq            <= |(irq_stat_next & irq_mask_next);
      scnt_reg       <= scnt_next;
      tcnt_reg       <= tcnt_next;
      pickup_reg     <= pickup_next;
      delay_reg      <= delay_next;
    end
  end

endmodule
`default_nettype wire

// [test/tsovd_chk.sv]
/*
  Port checker for the overvoltage detector top.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tsovd_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  start_out,
  input wire logic [2:0]  trip_out,
  input wire logic        irq
);
  // ==========================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence read_access;
    psel && penable && !pwrite;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> start_out == 3'h0
    && trip_out == 3'h0 && !irq && prdata == 32'h0) else $error("outputs busy after reset");
  a_slverr_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  a_unmapped_zero: assert property (read_access ##0 pslverr |=> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without read");
  a_trip_with_start: assert property ((trip_out & ~start_out) == 3'h0)
    else $error("trip without start");
  a_trip_after_start: assert property ((trip_out & ~$past(trip_out) & ~$past(start_out)) == 3'h0)
    else $error("trip rose before start");
  a_release_both: assert property ((~start_out & $past(start_out) & trip_out) == 3'h0)
    else $error("trip held after release");
endmodule
`default_nettype wire

// [test/tsovd_front.sv]
/*
  Measurement front end model: three line-to-line magnitudes.
  Assumes the bench picks the peak value and the phase that carries it.
*/
`timescale 1ns/1ps
`default_nettype none
module tsovd_front (
  input wire logic        sys_clk,
  input wire logic [15:0] peak,
  input wire logic [1:0]  ph,
  output logic     [15:0] u12,
  output logic     [15:0] u23,
  output logic     [15:0] u31
);
  // ==========================================================
  // Only fundamental magnitudes are delivered, other phases at nominal
  always_ff @(posedge sys_clk) begin
    u12 <= (ph == 2'h0) ? peak : 16'h01F4;
    u23 <= (ph == 2'h1) ? peak : 16'h01F4;
    u31 <= (ph == 2'h2) ? peak : 16'h01F4;
  end
endmodule
`default_nettype wire

// [test/tsovd_bench.sv]
/*
  Self-checking bench for the overvoltage detector over APB.
  Assumes tsovd_pkg, tsovd_top, tsovd_front and tsovd_chk are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tsovd_bench;
  import tsovd_pkg::*;
  // ==========================================================
  // Signals
  logic        sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0]  start_out, trip_out;
  logic [1:0]  grp_pin = 0, ph = 1;
  logic [15:0] peak = 16'h01F4, u12, u23, u31;
  logic [15:0] pk [3] = '{16'h03E8, 16'h07D0, 16'h0BB8};
  int          fails = 0, checked = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  tsovd_front i_tsovd_front (.sys_clk(sys_clk), .peak(peak), .ph(ph), .u12(u12), .u23(u23),
    .u31(u31));
  tsovd_top #(.FORCE_TIMEOUT(50)) i_tsovd_top (.sys_clk(sys_clk), .rst(rst), .u12_fund(u12),
    .u23_fund(u23), .u31_fund(u31), .group_select_in(grp_pin), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_out(start_out), .trip_out(trip_out), .irq(irq));
  // ==========================================================
  // Tasks
  task automatic cmp(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;  // Taken at the edge that completes the access
    psel <= 0; penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    tick(5); rst <= 0; tick(1);
    xfer(0, HYST_OFS, 0); cmp("hyst reset", rd, {22'h0, HYST_RST});
    xfer(0, SET_BASE_OFS + 12'h004, 0); cmp("delay reset", rd, DELAY_RST);
    xfer(0, 12'h0FC, 0); cmp("unmapped err", {31'h0, err}, 1); cmp("unmapped", rd, 0);
    for (int s = 0; s < 3; s++) begin
      xfer(1, SET_BASE_OFS + 12'(s * 64), {16'h0, pk[s]});
      xfer(1, SET_BASE_OFS + 12'(s * 64 + 4), 32'(20 >> s));
    end
    peak <= 16'h044C; tick(5); cmp("start low", start_out, 3'b001);
    xfer(0, UMAX_OFS, 0); cmp("umax", rd, 32'h044C);
    cmp("early trip", trip_out, 0); tick(20); cmp("trip low", trip_out, 3'b001);
    peak <= 16'h03CA; tick(5); cmp("hyst hold", start_out, 3'b001);
    peak <= 16'h03C9; tick(5); cmp("release", {trip_out, start_out}, 0);
    xfer(1, RELDLY_OFS, 32'h1E);
    peak <= 16'h044C; tick(12); cmp("short fault", trip_out, 0);
    peak <= 16'h0384; tick(10); peak <= 16'h044C; tick(18);
    cmp("resume trip", trip_out, 3'b001);
    peak <= 16'h0384; tick(45); peak <= 16'h044C; tick(18);
    cmp("timer cleared", trip_out, 0);
    peak <= 16'h01F4; tick(45);
    xfer(0, IRQ_STAT_OFS, 0); xfer(1, IRQ_MASK_OFS, 0);
    peak <= 16'h0DAC; tick(30); cmp("all trip", {trip_out, start_out}, 6'h3F);
    xfer(0, STATUS_OFS, 0); cmp("status", rd, 32'h0000_003F);
    cmp("masked irq", irq, 0); xfer(1, IRQ_MASK_OFS, 32'h3F); tick(2); cmp("irq", irq, 1);
    xfer(0, IRQ_STAT_OFS, 0); cmp("irq stat", rd, 32'h3F); tick(2); cmp("irq clr", irq, 0);
    xfer(0, CNT_BASE_OFS + 12'h008, 0); cmp("cnt stage2", rd, 32'h0001_0001);
    xfer(0, CNT_BASE_OFS + 12'h004, 0); cmp("cnt stage1", rd, 32'h0001_0001);
    peak <= 16'h01F4; tick(45);
    xfer(1, 12'h190, 32'h1388); xfer(1, CTRL_OFS, 1);
    peak <= 16'h0DAC; tick(5); cmp("group one", start_out, 0);
    xfer(1, CTRL_OFS, 5); tick(5); cmp("group pin", start_out[2], 1);
    grp_pin <= 1; tick(5); cmp("pin group one", start_out[2], 0);
    peak <= 16'h01F4; tick(45);
    xfer(1, CTRL_OFS, 8); xfer(0, CTRL_OFS, 0); cmp("force set", rd[3], 1);
    tick(60); xfer(0, CTRL_OFS, 0); cmp("force clr", rd[3], 0);
    complete_run();
  end
endmodule
bind tsovd_top tsovd_chk i_tsovd_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .start_out(start_out), .trip_out(trip_out), .irq(irq));
`default_nettype wire
